// File: pesc_consts.svh
// Constants for the performance event selector and counters.
// Assumes the includer wants plain text macros; no logic lives here.
//
// Contract
// - Code 14h with mask 00h counts every cycle the divider is busy, on counter zero only.
// - Code 18h counts divider-busy cycles with no younger unit or L1-hit load active, counter zero only.
// - Code 19h mask 00h counts each float op taking a non-float result at once, counter one only.
// - Code 19h mask 01h counts each vector op taking a non-vector result at once, counter one only.
// - Code 19h mask 02h adds the forwarding penalty cycles that loads incur, counter one only.
// - Code 21h counts cycles the second-level address bus is used, for this core or both cores.
// - Code 23h counts cycles the second-level data bus moves data to the core, per core choice.
// - Code 24h counts each line allocated into the second-level cache.
// - For code 24h the mask picks demand, prefetch or both, and this core or both cores.
// - Code 25h counts each modified line written back from the L1 data cache, per core choice.
`ifndef PESC_CONSTS_SVH
`define PESC_CONSTS_SVH

// ----------------------------------------------------------------
// Event codes and unit masks
// ----------------------------------------------------------------
`define PESC_EV_DIV_BUSY   8'h14
`define PESC_EV_IDLE_DIV   8'h18
`define PESC_EV_XFWD       8'h19
`define PESC_EV_L2_ADDR    8'h21
`define PESC_EV_L2_RD      8'h23
`define PESC_EV_L2_ALLOC   8'h24
`define PESC_EV_L2_DIRTY   8'h25
`define PESC_UM_NONE       8'h00
`define PESC_UM_XFWD_VEC   8'h01
`define PESC_UM_XFWD_LOAD  8'h02

// ----------------------------------------------------------------
// Unit mask fields
// ----------------------------------------------------------------
`define PESC_UM_CORE_HI    7
`define PESC_UM_CORE_LO    6
`define PESC_UM_PF_HI      5
`define PESC_UM_PF_LO      4
`define PESC_UM_CORE_RSV   8'h3f
`define PESC_UM_ALLOC_RSV  8'h0f
`define PESC_CORE_THIS     2'h1
`define PESC_CORE_BOTH     2'h3
`define PESC_PF_DEMAND     2'h0
`define PESC_PF_ONLY       2'h1
`define PESC_PF_ALL        2'h3

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define PESC_CNT_W         40
`define PESC_INC_W         3
`define PESC_CNT_RST       40'h0

`endif

// File: pesc_pkg.sv
// Types shared by the event selector and its counters.
// Assumes pesc_consts.svh is on the include path.
`default_nettype none
`include "pesc_consts.svh"

package pesc_pkg;

  // One counter's selection as written by the counter bank
  typedef struct packed {
    logic       enable;
    logic [7:0] event_code;
    logic [7:0] umask;
  } pesc_sel_t;

  // Event pulses and levels; bit 0 is this core, bit 1 the other core
  typedef struct packed {
    logic       div_start;
    logic       div_done;
    logic       young_exec_busy;
    logic       young_load_busy;
    logic       float_cross_unit_forward;
    logic       vector_cross_unit_forward;
    logic       load_forward_penalty;
    logic [1:0] second_level_addr_bus_cycles;
    logic [1:0] second_level_read_data_cycles;
    logic [1:0] alloc_demand;
    logic [1:0] alloc_prefetch;
    logic [1:0] dirty_line_writebacks_to_second_level;
  } pesc_events_t;

  typedef struct packed {
    logic                   ok;
    logic [`PESC_INC_W-1:0] inc;
  } pesc_hit_t;

  typedef enum logic {PESC_DIV_IDLE, PESC_DIV_RUN} pesc_div_state_t;

endpackage : pesc_pkg
`default_nettype wire

// File: pesc_divmon.sv
// Tracks divider occupancy and whether only the divider is working.
// Assumes start and done are one-cycle pulses from the divider.
`timescale 1ns/1ps
`default_nettype none
`include "pesc_consts.svh"

module pesc_divmon (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Divider and unit activity
  input  wire logic                   div_start,
  input  wire logic                   div_done,
  input  wire logic                   young_exec,
  input  wire logic                   young_load,
  // Status
  output logic                        busy,
  output logic                        quiet
);

  pesc_pkg::pesc_div_state_t state;
  pesc_pkg::pesc_div_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      pesc_pkg::PESC_DIV_IDLE: begin
        if (div_start && !div_done) begin
          next_state = pesc_pkg::PESC_DIV_RUN;
        end
      end
      pesc_pkg::PESC_DIV_RUN: begin
        if (div_done) begin
          next_state = pesc_pkg::PESC_DIV_IDLE;
        end
      end
      default: next_state = pesc_pkg::PESC_DIV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= pesc_pkg::PESC_DIV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Busy from the start cycle through the done cycle
  assign busy  = div_start || (state == pesc_pkg::PESC_DIV_RUN);
  assign quiet = busy && !young_exec && !young_load;

endmodule : pesc_divmon
`default_nettype wire

// File: pesc_accum.sv
// One general counter: loadable, adds a small increment each clock.
// Assumes load has priority over counting in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pesc_consts.svh"

module pesc_accum (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Load and increment
  input  wire logic                   load,
  input  wire logic [`PESC_CNT_W-1:0] load_value,
  input  wire logic [`PESC_INC_W-1:0] inc,
  // Value
  output logic      [`PESC_CNT_W-1:0] count
);

  logic [`PESC_CNT_W-1:0] next_count;

  // Wraps silently; overflow handling sits in the counter bank
  always_comb begin
    if (load) begin
      next_count = load_value;
    end else begin
      next_count = count + `PESC_CNT_W'(inc);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= `PESC_CNT_RST;
    end else begin
      count <= next_count;
    end
  end

endmodule : pesc_accum
`default_nettype wire

// File: pesc_top.sv
// Event selector and two general counters.
// Assumes event inputs are synchronous to CLK and selections are held
// steady by the counter bank while counting.
`timescale 1ns/1ps
`default_nettype none
`include "pesc_consts.svh"

module pesc_top (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SRST,
  // Counter selections
  input  wire pesc_pkg::pesc_sel_t    SEL0,
  input  wire pesc_pkg::pesc_sel_t    SEL1,
  // Event sources
  input  wire pesc_pkg::pesc_events_t EVENTS,
  // Counter loads
  input  wire logic                   LOAD0,
  input  wire logic                   LOAD1,
  input  wire logic [`PESC_CNT_W-1:0] LOAD_VALUE,
  // Counter values and selection status
  output logic      [`PESC_CNT_W-1:0] COUNT0,
  output logic      [`PESC_CNT_W-1:0] COUNT1,
  output logic      [1:0]             SEL_OK
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [`PESC_INC_W-1:0] pesc_core_sum(
    input logic [1:0] v,
    input logic [1:0] core
  );
    logic [`PESC_INC_W-1:0] r;
    r = '0;
    if (core == `PESC_CORE_BOTH) begin
      r = `PESC_INC_W'(v[0]) + `PESC_INC_W'(v[1]);
    end else if (core == `PESC_CORE_THIS) begin
      r = `PESC_INC_W'(v[0]);
    end
    return r;
  endfunction : pesc_core_sum

  function automatic pesc_pkg::pesc_hit_t pesc_decode(
    input logic                  is_one,
    input pesc_pkg::pesc_sel_t   s,
    input pesc_pkg::pesc_events_t e,
    input logic                  busy,
    input logic                  quiet
  );
    pesc_pkg::pesc_hit_t h;
    logic [1:0]          core;
    logic [1:0]          pf;
    logic                core_ok;
    h       = '0;
    core    = s.umask[`PESC_UM_CORE_HI:`PESC_UM_CORE_LO];
    pf      = s.umask[`PESC_UM_PF_HI:`PESC_UM_PF_LO];
    core_ok = (core == `PESC_CORE_THIS) || (core == `PESC_CORE_BOTH);
    case (s.event_code)
      `PESC_EV_DIV_BUSY: begin
        h.ok  = !is_one && (s.umask == `PESC_UM_NONE);
        h.inc = `PESC_INC_W'(busy);
      end
      `PESC_EV_IDLE_DIV: begin
        h.ok  = !is_one && (s.umask == `PESC_UM_NONE);
        h.inc = `PESC_INC_W'(quiet);
      end
      `PESC_EV_XFWD: begin
        h.ok = is_one;
        case (s.umask)
          `PESC_UM_NONE:      h.inc = `PESC_INC_W'(e.float_cross_unit_forward);
          `PESC_UM_XFWD_VEC:  h.inc = `PESC_INC_W'(e.vector_cross_unit_forward);
          `PESC_UM_XFWD_LOAD: h.inc = `PESC_INC_W'(e.load_forward_penalty);
          default:            h.ok  = 1'b0;
        endcase
      end
      `PESC_EV_L2_ADDR: begin
        h.ok  = core_ok && ((s.umask & `PESC_UM_CORE_RSV) == 8'h00);
        h.inc = pesc_core_sum(e.second_level_addr_bus_cycles, core);
      end
      `PESC_EV_L2_RD: begin
        h.ok  = core_ok && ((s.umask & `PESC_UM_CORE_RSV) == 8'h00);
        h.inc = pesc_core_sum(e.second_level_read_data_cycles, core);
      end
      `PESC_EV_L2_ALLOC: begin
        h.ok = core_ok && ((s.umask & `PESC_UM_ALLOC_RSV) == 8'h00);
        case (pf)
          `PESC_PF_ALL:    h.inc = pesc_core_sum(e.alloc_demand, core)
                                 + pesc_core_sum(e.alloc_prefetch, core);
          `PESC_PF_ONLY:   h.inc = pesc_core_sum(e.alloc_prefetch, core);
          `PESC_PF_DEMAND: h.inc = pesc_core_sum(e.alloc_demand, core);
          default:         h.ok  = 1'b0;
        endcase
      end
      `PESC_EV_L2_DIRTY: begin
        h.ok  = core_ok && ((s.umask & `PESC_UM_CORE_RSV) == 8'h00);
        h.inc = pesc_core_sum(e.dirty_line_writebacks_to_second_level, core);
      end
      default: h.ok = 1'b0;
    endcase
    if (!h.ok || !s.enable) begin
      h.inc = '0;
    end
    return h;
  endfunction : pesc_decode

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // One register stage keeps long source wires off the adder path
  pesc_pkg::pesc_events_t ev_q;
  pesc_pkg::pesc_events_t next_ev_q;
  logic                   div_busy;
  logic                   div_quiet;

  always_comb begin
    next_ev_q = EVENTS;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_q <= '0;
    end else begin
      ev_q <= next_ev_q;
    end
  end

  pesc_divmon u_divmon (
    .clk        (CLK),
    .srst       (SRST),
    .div_start  (ev_q.div_start),
    .div_done   (ev_q.div_done),
    .young_exec (ev_q.young_exec_busy),
    .young_load (ev_q.young_load_busy),
    .busy       (div_busy),
    .quiet      (div_quiet)
  );

  // ----------------------------------------------------------------
  // Selection and counting
  // ----------------------------------------------------------------
  pesc_pkg::pesc_hit_t hit0;
  pesc_pkg::pesc_hit_t hit1;
  logic [1:0]          next_sel_ok;

  always_comb begin
    hit0        = pesc_decode(1'b0, SEL0, ev_q, div_busy, div_quiet);
    hit1        = pesc_decode(1'b1, SEL1, ev_q, div_busy, div_quiet);
    next_sel_ok = {hit1.ok, hit0.ok};
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SEL_OK <= 2'h0;
    end else begin
      SEL_OK <= next_sel_ok;
    end
  end

  pesc_accum u_cnt0 (
    .clk        (CLK),
    .srst       (SRST),
    .load       (LOAD0),
    .load_value (LOAD_VALUE),
    .inc        (hit0.inc),
    .count      (COUNT0)
  );

  pesc_accum u_cnt1 (
    .clk        (CLK),
    .srst       (SRST),
    .load       (LOAD1),
    .load_value (LOAD_VALUE),
    .inc        (hit1.inc),
    .count      (COUNT1)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic sel0_on;
  logic sel1_on;
  assign sel0_on = SEL0.enable && !LOAD0 && !SRST;
  assign sel1_on = SEL1.enable && !LOAD1 && !SRST;

  div_busy_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_DIV_BUSY && SEL0.umask == `PESC_UM_NONE
     && $past(ev_q.div_start) == 1'b0 && ev_q.div_start)
    |=> COUNT0 == $past(COUNT0) + 40'h1)
    else $error("divider busy cycle not counted");

  idle_div_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_IDLE_DIV && SEL0.umask == `PESC_UM_NONE)
    |=> COUNT0 == $past(COUNT0) + 40'(
        $past(div_busy && !ev_q.young_exec_busy && !ev_q.young_load_busy)))
    else $error("divider-alone count wrong");

  fp_fwd_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_XFWD && SEL1.umask == `PESC_UM_NONE)
    |=> COUNT1 == $past(COUNT1) + 40'($past(ev_q.float_cross_unit_forward)))
    else $error("float forward count wrong");

  vec_fwd_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_XFWD && SEL1.umask == `PESC_UM_XFWD_VEC
     && ev_q.vector_cross_unit_forward)
    |=> COUNT1 == $past(COUNT1) + 40'h1)
    else $error("vector forward not counted");

  load_pen_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_XFWD && SEL1.umask == `PESC_UM_XFWD_LOAD)
    |=> COUNT1 == $past(COUNT1) + 40'($past(ev_q.load_forward_penalty)))
    else $error("load penalty count wrong");

  addr_both_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_L2_ADDR && SEL1.umask == 8'hc0)
    |=> COUNT1 == $past(COUNT1) + 40'($past(ev_q.second_level_addr_bus_cycles[0]))
                 + 40'($past(ev_q.second_level_addr_bus_cycles[1])))
    else $error("address bus both-core count wrong");

  rd_this_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_L2_RD && SEL0.umask == 8'h40)
    |=> COUNT0 == $past(COUNT0) + 40'($past(ev_q.second_level_read_data_cycles[0])))
    else $error("read data this-core count wrong");

  alloc_all_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_L2_ALLOC && SEL0.umask == 8'h70)
    |=> COUNT0 == $past(COUNT0) + 40'($past(ev_q.alloc_demand[0]))
                 + 40'($past(ev_q.alloc_prefetch[0])))
    else $error("allocation count wrong");

  alloc_pf_only_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_L2_ALLOC && SEL1.umask == 8'hd0)
    |=> COUNT1 == $past(COUNT1) + 40'($past(ev_q.alloc_prefetch[0]))
                 + 40'($past(ev_q.alloc_prefetch[1])))
    else $error("prefetch allocation count wrong");

  dirty_wb_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_L2_DIRTY && SEL0.umask == 8'h40
     && ev_q.dirty_line_writebacks_to_second_level[0])
    |=> COUNT0 == $past(COUNT0) + 40'h1)
    else $error("dirty write-back not counted");

  wrong_cnt_hold_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && (SEL1.event_code == `PESC_EV_DIV_BUSY
                 || SEL1.event_code == `PESC_EV_IDLE_DIV))
    |=> COUNT1 == $past(COUNT1) ##0 SEL_OK[1] == 1'b0)
    else $error("forbidden counter placement counted");

  div_done_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_DIV_BUSY && SEL0.umask == `PESC_UM_NONE
     && ev_q.div_done)
    |=> COUNT0 == $past(COUNT0) + 40'h1)
    else $error("divider last busy cycle not counted");

  rd_both_cnt_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_L2_RD && SEL1.umask == 8'hc0)
    |=> COUNT1 == $past(COUNT1) + 40'($past(ev_q.second_level_read_data_cycles[0]))
                 + 40'($past(ev_q.second_level_read_data_cycles[1])))
    else $error("read data both-core count wrong");

  // ----------------------------------------------------------------
  // Refusal checks
  // ----------------------------------------------------------------
  sel_off_hold_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (!SEL0.enable && !LOAD0)
    |=> COUNT0 == $past(COUNT0))
    else $error("disabled counter moved");

  xfwd_cnt0_hold_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel0_on && SEL0.event_code == `PESC_EV_XFWD)
    |=> COUNT0 == $past(COUNT0) ##0 SEL_OK[0] == 1'b0)
    else $error("forwarding event counted on counter zero");

  rsv_umask_hold_a: assert property (
    @(posedge CLK) disable iff (SRST)
    (sel1_on && SEL1.event_code == `PESC_EV_L2_ADDR && SEL1.umask[5:0] != 6'h00)
    |=> COUNT1 == $past(COUNT1) ##0 SEL_OK[1] == 1'b0)
    else $error("reserved mask bits counted");

endmodule : pesc_top
`default_nettype wire

// File: pesc_src_model.sv
// Model of the execution units and caches that feed the event selector.
// Assumes the bench calls play only at a falling edge of clk.
`timescale 1ns/1ps
`default_nettype none

module pesc_src_model (
  // Clock
  input  wire logic                   clk,
  // Event outputs
  output var pesc_pkg::pesc_events_t  events
);
  initial begin
    events = '0;
  end

  // Holds one pattern for n cycles. Patterns change only at falling edges,
  // so the selector never samples a half-changed set of sources.
  task automatic play(input pesc_pkg::pesc_events_t e, input int n);
    events = e;
    repeat (n) @(negedge clk);
  endtask : play
endmodule : pesc_src_model

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the event selector and its two counters.
// Assumes pesc_pkg is compiled first; the source model drives EVENTS.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                   CLK;
  logic                   SRST;
  pesc_pkg::pesc_sel_t    SEL0;
  pesc_pkg::pesc_sel_t    SEL1;
  pesc_pkg::pesc_events_t EVENTS;
  pesc_pkg::pesc_events_t rst_ev;
  logic                   LOAD0;
  logic                   LOAD1;
  logic [39:0]            LOAD_VALUE;
  logic [39:0]            COUNT0;
  logic [39:0]            COUNT1;
  logic [1:0]             SEL_OK;
  int                     bad_count;
  int                     tests_run;
  int                     cycles;

  pesc_src_model src (.clk(CLK), .events(EVENTS));

  pesc_top DUT (
    .CLK(CLK), .SRST(SRST), .SEL0(SEL0), .SEL1(SEL1), .EVENTS(EVENTS),
    .LOAD0(LOAD0), .LOAD1(LOAD1), .LOAD_VALUE(LOAD_VALUE),
    .COUNT0(COUNT0), .COUNT1(COUNT1), .SEL_OK(SEL_OK)
  );

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic pesc_pkg::pesc_sel_t mk(input logic en, input logic [7:0] code,
                                             input logic [7:0] um);
    mk = {en, code, um};
  endfunction : mk

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Clears both counters by load; SEL_OK settles one edge later
  task automatic setup(input pesc_pkg::pesc_sel_t s0, input pesc_pkg::pesc_sel_t s1);
    SEL0 = s0;
    SEL1 = s1;
    LOAD0 = 1'b1;
    LOAD1 = 1'b1;
    LOAD_VALUE = '0;
    @(negedge CLK);
    LOAD0 = 1'b0;
    LOAD1 = 1'b0;
    @(negedge CLK);
  endtask : setup

  // Five busy cycles; only cycles 0, 3 and 4 have the divider alone
  task automatic div_seq;
    pesc_pkg::pesc_events_t e;
    e = '0;
    e.div_start = 1'b1;
    src.play(e, 1);
    e = '0;
    e.young_exec_busy = 1'b1;
    src.play(e, 1);
    e = '0;
    e.young_load_busy = 1'b1;
    src.play(e, 1);
    src.play('0, 1);
    e = '0;
    e.div_done = 1'b1;
    src.play(e, 1);
    src.play('0, 3);
  endtask : div_seq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_div;
    setup(mk(1'b1, 8'h14, 8'h00), mk(1'b1, 8'h14, 8'h00));
    div_seq();
    check("div busy count0", COUNT0, 40'h5);
    check("div busy count1", COUNT1, 40'h0);
    check("div busy sel ok", 40'(SEL_OK), 40'h1);
    setup(mk(1'b1, 8'h18, 8'h00), mk(1'b1, 8'h18, 8'h00));
    div_seq();
    check("div alone count0", COUNT0, 40'h3);
    check("div alone count1", COUNT1, 40'h0);
    check("div alone sel ok", 40'(SEL_OK), 40'h1);
    $display("test div done");
  endtask : t_div

  task automatic t_xfwd;
    pesc_pkg::pesc_events_t e;
    for (int m = 0; m < 4; m++) begin
      setup(mk(1'b1, 8'h19, 8'h00), mk(1'b1, 8'h19, 8'(m)));
      e = '0;
      e.float_cross_unit_forward = 1'b1;
      src.play(e, 1);
      e = '0;
      e.vector_cross_unit_forward = 1'b1;
      src.play(e, 2);
      e = '0;
      e.load_forward_penalty = 1'b1;
      src.play(e, 3);
      src.play('0, 3);
      check("xfwd count1", COUNT1, (m < 3) ? 40'(m + 1) : 40'h0);
      check("xfwd count0", COUNT0, 40'h0);
      check("xfwd sel ok", 40'(SEL_OK), (m < 3) ? 40'h2 : 40'h0);
    end
    $display("test xfwd done");
  endtask : t_xfwd

  // Selected source steps through 01, 10, 11; the others stay fully busy
  task automatic t_l2;
    pesc_pkg::pesc_events_t e;
    logic [7:0] codes [3];
    codes = '{8'h21, 8'h23, 8'h25};
    for (int i = 0; i < 3; i++) begin
      setup(mk(1'b1, codes[i], 8'h40), mk(1'b1, codes[i], 8'hc0));
      for (int v = 1; v < 4; v++) begin
        e = '0;
        e.second_level_addr_bus_cycles = (i == 0) ? 2'(v) : 2'h3;
        e.second_level_read_data_cycles = (i == 1) ? 2'(v) : 2'h3;
        e.dirty_line_writebacks_to_second_level = (i == 2) ? 2'(v) : 2'h3;
        src.play(e, 1);
      end
      src.play('0, 3);
      check("l2 this core", COUNT0, 40'h2);
      check("l2 both cores", COUNT1, 40'h4);
      check("l2 sel ok", 40'(SEL_OK), 40'h3);
    end
    $display("test l2 done");
  endtask : t_l2

  task automatic t_alloc;
    pesc_pkg::pesc_events_t e;
    logic [1:0]  pfs [4];
    logic [1:0]  dem [2];
    logic [1:0]  pre [2];
    logic [39:0] this_n;
    logic [39:0] both_n;
    pfs = '{2'h0, 2'h1, 2'h3, 2'h2};
    dem = '{2'h3, 2'h1};
    pre = '{2'h1, 2'h3};
    foreach (pfs[k]) begin
      setup(mk(1'b1, 8'h24, {2'h1, pfs[k], 4'h0}), mk(1'b1, 8'h24, {2'h3, pfs[k], 4'h0}));
      this_n = '0;
      both_n = '0;
      for (int c = 0; c < 2; c++) begin
        e = '0;
        e.alloc_demand = dem[c];
        e.alloc_prefetch = pre[c];
        e.second_level_addr_bus_cycles = 2'h3;
        src.play(e, 1);
        if (pfs[k] == 2'h0 || pfs[k] == 2'h3) begin
          this_n += 40'(dem[c][0]);
          both_n += 40'($countones(dem[c]));
        end
        if (pfs[k][0]) begin
          this_n += 40'(pre[c][0]);
          both_n += 40'($countones(pre[c]));
        end
      end
      src.play('0, 3);
      check("alloc this core", COUNT0, this_n);
      check("alloc both cores", COUNT1, both_n);
      check("alloc sel ok", 40'(SEL_OK), (pfs[k] == 2'h2) ? 40'h0 : 40'h3);
    end
    $display("test alloc done");
  endtask : t_alloc

  task automatic t_refuse(input pesc_pkg::pesc_sel_t s0, input pesc_pkg::pesc_sel_t s1,
                          input logic [39:0] ok);
    setup(s0, s1);
    src.play('1, 2);
    src.play('0, 3);
    check("refuse count0", COUNT0, 40'h0);
    check("refuse count1", COUNT1, 40'h0);
    check("refuse sel ok", 40'(SEL_OK), ok);
    $display("test refuse done");
  endtask : t_refuse

  // Load lands mid-burst, beats that cycle's increment, then wraps
  task automatic t_load;
    pesc_pkg::pesc_events_t e;
    setup(mk(1'b1, 8'h21, 8'h40), mk(1'b1, 8'h21, 8'h40));
    e = '0;
    e.second_level_addr_bus_cycles = 2'h1;
    fork
      src.play(e, 4);
      begin
        repeat (2) @(negedge CLK);
        LOAD0 = 1'b1;
        LOAD_VALUE = 40'hff_ffff_fffe;
        @(negedge CLK);
        LOAD0 = 1'b0;
        check("load value", COUNT0, 40'hff_ffff_fffe);
      end
    join
    src.play('0, 3);
    check("load wrap", COUNT0, 40'h0);
    check("load other", COUNT1, 40'h4);
    $display("test load done");
  endtask : t_load

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    SRST = 1'b1;
    LOAD0 = 1'b0;
    LOAD1 = 1'b0;
    LOAD_VALUE = '0;
    SEL0 = mk(1'b1, 8'h21, 8'h40);
    SEL1 = '0;
    rst_ev = '0;
    rst_ev.second_level_addr_bus_cycles = 2'h1;
    @(negedge CLK);
    src.play(rst_ev, 3);
    check("reset count0", COUNT0, 40'h0);
    check("reset sel ok", 40'(SEL_OK), 40'h0);
    src.play('0, 0);
    SRST = 1'b0;
    $display("test reset done");
    t_div();
    t_xfwd();
    t_l2();
    t_alloc();
    t_refuse(mk(1'b0, 8'h21, 8'h40), mk(1'b1, 8'h21, 8'h41), 40'h1);
    t_refuse(mk(1'b1, 8'h22, 8'h40), mk(1'b1, 8'h23, 8'h00), 40'h0);
    t_load();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
